/* rtl/eebac_pkg.sv */
// constants and types shared by the eeprom byte access control block
// What this block does
// - program starts only if go written while armed
// - arm bit clears itself four cycles later
// - go write without arm is ignored
// - go starts selected mode, stays set while busy
// - hardware clears go when programming time ends
// - programming start stalls processor two cycles
// - read strobe loads data register two cycles later
// - each read stalls processor four cycles
// - busy blocks reads and address changes
// - busy refuses any other eeprom operation
// - mode zero erases and writes atomically
// - mode 01 erases only, 10 writes only
// - write-only needs a previously erased byte
// - programming timed by calibrated oscillator ticks
// - programming finishes even across system reset
// - low registers allow bit set, clear, test
// - io addresses 0x00-0x3F, data space plus 0x20
// - bit set and clear touch only that bit
// - status flags clear by writing one
// - mode locked while busy, resets unless busy
// - ready interrupt while enabled and not busy
// - six-bit address, upper bits read zero
package eebac_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [5:0] OFS_CTRL    = 6'h1C;
  localparam logic [5:0] OFS_DATA    = 6'h1D;
  localparam logic [5:0] OFS_ADDR    = 6'h1E;
  localparam logic [5:0] OFS_STAT    = 6'h1F;
  localparam logic [5:0] BITOP_LAST  = 6'h1F;
  localparam logic [6:0] IO_LAST     = 7'h3F;
  localparam logic [6:0] DS_OFFSET   = 7'h20;
  localparam logic [6:0] DS_LAST     = 7'h5F;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_READ   = 0;
  localparam int CTRL_GO     = 1;
  localparam int CTRL_ARM    = 2;
  localparam int CTRL_IRQEN  = 3;
  localparam int CTRL_MODE   = 4;
  localparam int STAT_REFUSE = 0;
  localparam logic [5:0] ADDR_RST = 6'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int  CLK_PERIOD_NS = 10;
  localparam int  ARM_WINDOW    = 4;
  localparam int  STALL_PROG    = 2;
  localparam int  STALL_READ    = 4;
  localparam real T_ATOMIC_MS   = 3.4;
  localparam real T_SPLIT_MS    = 1.8;
  localparam int  OSC_TICK_NS   = 1000;
  localparam int  TICK_W        = 12;
  localparam int  ATOMIC_TICKS  = int'(T_ATOMIC_MS * 1.0e6 / OSC_TICK_NS);
  localparam int  SPLIT_TICKS   = int'(T_SPLIT_MS * 1.0e6 / OSC_TICK_NS);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PM_ATOMIC = 2'h0,
    PM_ERASE  = 2'h1,
    PM_WRITE  = 2'h2,
    PM_RSVD   = 2'h3
  } eebac_mode_t;

  typedef enum logic [1:0] {
    ES_IDLE   = 2'h0,
    ES_RUN    = 2'h1,
    ES_FINISH = 2'h3
  } eebac_state_t;

endpackage

/* rtl/eebac_countdown.sv */
// down counter whose nonzero count marks a window of cycles
`timescale 1ns/1ns
module eebac_countdown #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              active
);
  import eebac_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } eebac_cd_t;

  eebac_cd_t s;
  eebac_cd_t next_s;

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.cnt = load_val;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign active = (s.cnt != '0);

endmodule

/* rtl/eebac_engine.sv */
// programming engine: mode, busy, oscillator timing, array strobes
`timescale 1ns/1ns
module eebac_engine #(
  parameter int ATOMIC_T = eebac_pkg::ATOMIC_TICKS,
  parameter int SPLIT_T  = eebac_pkg::SPLIT_TICKS
) (
  input  wire logic              clk,
  input  wire logic              por_rst,
  input  wire logic              sys_rst,
  input  wire logic              start,
  input  wire logic              mode_wr,
  input  wire eebac_pkg::eebac_mode_t mode_wdata,
  input  wire logic [5:0]        addr_in,
  input  wire logic [7:0]        data_in,
  input  wire logic              rd_req,
  input  wire logic              osc_tick,
  output eebac_pkg::eebac_mode_t mode,
  output logic                   busy,
  output logic [5:0]             arr_addr,
  output logic [7:0]             arr_wdata,
  output logic                   arr_erase,
  output logic                   arr_write,
  output logic                   arr_rd
);
  import eebac_pkg::*;

  typedef struct packed {
    eebac_state_t      st;
    eebac_mode_t       mode;
    logic [TICK_W-1:0] ticks;
    logic [5:0]        addr;
    logic [7:0]        wdata;
    logic              erase;
    logic              write;
    logic              rd;
  } eebac_eng_t;

  eebac_eng_t s;
  eebac_eng_t next_s;

  always_comb begin
    next_s       = s;
    next_s.erase = 1'b0;
    next_s.write = 1'b0;
    next_s.rd    = 1'b0;
    case (s.st)
      ES_IDLE: begin
        if (start) begin
          next_s.addr  = addr_in;
          next_s.wdata = data_in;
          next_s.ticks = (s.mode == PM_ATOMIC) ? TICK_W'(ATOMIC_T)
                                               : TICK_W'(SPLIT_T);
          if (s.mode == PM_RSVD) begin
            next_s.st = ES_FINISH;
          end else begin
            next_s.st    = ES_RUN;
            next_s.erase = (s.mode != PM_WRITE);
            // unerased target yields lost data, software erases first
            next_s.write = (s.mode != PM_ERASE);
          end
        end else if (rd_req) begin
          next_s.addr = addr_in;
          next_s.rd   = 1'b1;
        end
        if (mode_wr && !start) begin
          next_s.mode = mode_wdata;
        end
      end
      ES_RUN: begin
        // time base is the oscillator, not the core clock
        if (osc_tick) begin
          if (s.ticks <= TICK_W'(1)) begin
            next_s.st = ES_FINISH;
          end else begin
            next_s.ticks = s.ticks - TICK_W'(1);
          end
        end
      end
      ES_FINISH: begin
        next_s.st = ES_IDLE;
      end
      default: begin
        next_s.st = ES_IDLE;
      end
    endcase
    // system reset clears the mode only when nothing is programming
    if (sys_rst && s.st == ES_IDLE) begin
      next_s.mode = PM_ATOMIC;
    end
  end

  // only power-on reset stops a running program cycle
  always_ff @(posedge clk or posedge por_rst) begin
    if (por_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mode      = s.mode;
  assign busy      = (s.st != ES_IDLE);
  assign arr_addr  = s.addr;
  assign arr_wdata = s.wdata;
  assign arr_erase = s.erase;
  assign arr_write = s.write;
  assign arr_rd    = s.rd;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (por_rst);

  sequence s_rsvd_start;
    start && !busy && mode == PM_RSVD;
  endsequence

  a_reserved_noop: assert property (
    s_rsvd_start |=> busy && !arr_erase && !arr_write ##1 !busy)
    else $error("reserved mode did not finish as a no-op");
  a_atomic_both: assert property (
    start && !busy && mode == PM_ATOMIC |=> arr_erase && arr_write)
    else $error("atomic mode did not erase and write");
  a_split_ops: assert property (
    start && !busy && mode inside {PM_ERASE, PM_WRITE} |=>
      (arr_erase != arr_write) && (arr_write == ($past(mode) == PM_WRITE)))
    else $error("split mode issued wrong strobe");
  a_tick_timing: assert property (
    s.st == ES_RUN && !osc_tick |=> s.st == ES_RUN && $stable(s.ticks))
    else $error("program timer moved without oscillator tick");
  a_mode_locked: assert property (
    busy |=> $stable(mode))
    else $error("mode changed while busy");
  a_reset_survive: assert property (
    busy && s.st == ES_RUN && sys_rst && !osc_tick |=> busy)
    else $error("system reset aborted programming");

endmodule

/* rtl/eebac_top.sv */
// eeprom byte access control: io registers, arming, stalls, reads
`timescale 1ns/1ns
module eebac_top #(
  parameter int ATOMIC_T = eebac_pkg::ATOMIC_TICKS,
  parameter int SPLIT_T  = eebac_pkg::SPLIT_TICKS
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       por_rst,
  input  wire logic [6:0] io_addr,
  input  wire logic       io_ds,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic       io_sbi,
  input  wire logic       io_cbi,
  input  wire logic [2:0] io_bit_sel,
  input  wire logic [7:0] io_wdata,
  output logic [7:0]      io_rdata,
  output logic            io_bit_val,
  output logic            cpu_stall,
  input  wire logic       gie,
  output logic            ready_irq,
  input  wire logic       osc_tick,
  output logic [5:0]      arr_addr,
  output logic [7:0]      arr_wdata,
  output logic            arr_erase,
  output logic            arr_write,
  output logic            arr_rd,
  input  wire logic [7:0] arr_rdata
);
  import eebac_pkg::*;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // returns {hit, io offset}; data space sits 0x20 above io space
  function automatic logic [6:0] io_decode(input logic [6:0] a,
                                           input logic       ds);
    logic [6:0] off;
    off = a - DS_OFFSET;
    if (ds) begin
      io_decode = {(a >= DS_OFFSET) && (a <= DS_LAST), off[5:0]};
    end else begin
      io_decode = {(a <= IO_LAST), a[5:0]};
    end
  endfunction

  // merges new bits into old under a write mask
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] val,
                                       input logic [7:0] m);
    merge = (old & ~m) | (val & m);
  endfunction

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic       irq_en;
    logic       refused;
    logic       rd_pend;
    logic [7:0] rdata;
    logic       bit_val;
  } eebac_regs_t;

  eebac_regs_t s;
  eebac_regs_t next_s;

  logic [6:0]  dec;
  logic        hit;
  logic [5:0]  off;
  logic        bitop;
  logic [7:0]  wmask;
  logic [7:0]  wval;
  logic [7:0]  ctrl_m;
  logic [7:0]  data_m;
  logic [7:0]  addr_m;
  logic [7:0]  stat_m;
  logic        go_req;
  logic        rd_req;
  logic        arm_load;
  logic        arm;
  logic        busy;
  logic        start;
  logic        rd_go;
  logic        refuse_ev;
  logic        mode_wr;
  logic [7:0]  mode_merged;
  logic [7:0]  ctrl_merged;
  logic [7:0]  addr_merged;
  logic [7:0]  ctrl_view;
  logic [7:0]  rd_mux;
  eebac_mode_t mode;

  assign dec = io_decode(io_addr, io_ds);
  assign hit = dec[6];
  assign off = dec[5:0];

  // ****************************************************************
  // write strobes
  // ****************************************************************
  // a bit set or clear becomes a one-bit write mask, so the other
  // bits of the register, flags included, see no write at all
  assign bitop = (io_sbi || io_cbi) && (off <= BITOP_LAST);

  always_comb begin
    wmask = 8'h00;
    wval  = 8'h00;
    if (hit && io_wr) begin
      wmask = 8'hFF;
      wval  = io_wdata;
    end else if (hit && bitop) begin
      wmask = 8'h01 << io_bit_sel;
      wval  = io_sbi ? 8'hFF : 8'h00;
    end
  end

  assign ctrl_m = (off == OFS_CTRL) ? wmask : 8'h00;
  assign data_m = (off == OFS_DATA) ? wmask : 8'h00;
  assign addr_m = (off == OFS_ADDR) ? wmask : 8'h00;
  assign stat_m = (off == OFS_STAT) ? wmask : 8'h00;

  assign go_req   = ctrl_m[CTRL_GO] && wval[CTRL_GO];
  assign rd_req   = ctrl_m[CTRL_READ] && wval[CTRL_READ];
  assign arm_load = ctrl_m[CTRL_ARM] && wval[CTRL_ARM];

  // go without arm has no effect; go while busy starts nothing and only sets the refusal flag
  assign start = go_req && arm && !busy;
  // reads are refused while busy; a start in the same write takes precedence
  assign rd_go = rd_req && !busy && !start;

  assign refuse_ev = (busy && (go_req || rd_req || (addr_m != 8'h00)))
                  || (rd_req && start);

  assign mode_wr     = (ctrl_m[CTRL_MODE+1 -: 2] != 2'h0) && !busy;
  assign mode_merged = merge({2'h0, mode, 4'h0}, wval, ctrl_m);
  assign ctrl_merged = merge(ctrl_view, wval, ctrl_m);
  assign addr_merged = merge({2'h0, s.addr}, wval, addr_m);

  // ****************************************************************
  // arm window and stall counters
  // ****************************************************************
  eebac_countdown #(
    .W (3)
  ) u_arm (
    .clk      (clk),
    .rst      (sys_rst),
    .load     (arm_load),
    .load_val (3'(ARM_WINDOW)),
    .active   (arm)
  );

  eebac_countdown #(
    .W (3)
  ) u_stall (
    .clk      (clk),
    .rst      (sys_rst),
    .load     (start || rd_go),
    .load_val (start ? 3'(STALL_PROG) : 3'(STALL_READ)),
    .active   (cpu_stall)
  );

  // ****************************************************************
  // programming engine
  // ****************************************************************
  eebac_engine #(
    .ATOMIC_T (ATOMIC_T),
    .SPLIT_T  (SPLIT_T)
  ) u_engine (
    .clk        (clk),
    .por_rst    (por_rst),
    .sys_rst    (sys_rst),
    .start      (start),
    .mode_wr    (mode_wr),
    .mode_wdata (eebac_mode_t'(mode_merged[CTRL_MODE+1 -: 2])),
    .addr_in    (s.addr),
    .data_in    (s.data),
    .rd_req     (rd_go),
    .osc_tick   (osc_tick),
    .mode       (mode),
    .busy       (busy),
    .arr_addr   (arr_addr),
    .arr_wdata  (arr_wdata),
    .arr_erase  (arr_erase),
    .arr_write  (arr_write),
    .arr_rd     (arr_rd)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  // read strobe always reads back as zero
  assign ctrl_view = {2'h0, mode, s.irq_en, arm, busy, 1'b0};

  always_comb begin
    rd_mux = 8'h00;
    case (off)
      OFS_CTRL: rd_mux = ctrl_view;
      OFS_DATA: rd_mux = s.data;
      OFS_ADDR: rd_mux = {2'h0, s.addr};
      OFS_STAT: rd_mux = {7'h00, s.refused};
      default:  rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_s         = s;
    next_s.rd_pend = rd_go;
    next_s.irq_en  = ctrl_merged[CTRL_IRQEN];
    next_s.data    = merge(s.data, wval, data_m);
    if (s.rd_pend) begin
      next_s.data = arr_rdata;
    end
    if (!busy) begin
      next_s.addr = addr_merged[5:0];
    end
    // a refusal in the same cycle as the clear is kept
    next_s.refused = refuse_ev ||
      (s.refused && !(stat_m[STAT_REFUSE] && wval[STAT_REFUSE]));
    if (io_rd) begin
      next_s.rdata   = hit ? rd_mux : 8'h00;
      next_s.bit_val = hit ? rd_mux[io_bit_sel] : 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s      <= '0;
      s.addr <= ADDR_RST;
      s.data <= DATA_RST;
    end else begin
      s <= next_s;
    end
  end

  assign io_rdata   = s.rdata;
  assign io_bit_val = s.bit_val;
  assign ready_irq  = s.irq_en && gie && !busy;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || por_rst);

  sequence s_arm_quiet;
    arm_load ##1 !arm_load [*4];
  endsequence

  sequence s_flag_clear;
    stat_m[STAT_REFUSE] && wval[STAT_REFUSE] && !refuse_ev;
  endsequence

  a_arm_window: assert property (
    arm_load |=> arm [*4])
    else $error("arm bit not held for four cycles");
  a_arm_expire: assert property (
    s_arm_quiet |=> !arm)
    else $error("arm bit not cleared after four cycles");
  a_start_armed: assert property (
    $rose(busy) |-> $past(arm) && $past(go_req))
    else $error("programming began without arming");
  a_prog_stall: assert property (
    $rose(busy) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("program stall not two cycles");
  a_read_stall: assert property (
    rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  a_read_data: assert property (
    rd_go |=> arr_rd && arr_addr == $past(s.addr) ##1
      s.data == $past(arr_rdata))
    else $error("read data not captured");
  a_addr_locked: assert property (
    busy |=> $stable(s.addr))
    else $error("address changed while busy");
  a_no_read_busy: assert property (
    busy |-> !rd_go && !arr_rd)
    else $error("read issued while busy");
  a_refuse_flag: assert property (
    refuse_ev |=> s.refused)
    else $error("refusal flag lost");
  a_ready_irq: assert property (
    busy |-> !ready_irq)
    else $error("ready interrupt while busy");
  a_go_unarmed: assert property (
    go_req && !arm && !busy |=> !busy)
    else $error("program started without arming");
  a_addr_write: assert property (
    !busy && addr_m == 8'hFF |=> s.addr == $past(wval[5:0]))
    else $error("address write did not land");
  a_addr_upper: assert property (
    io_rd && hit && off == OFS_ADDR |=> io_rdata[7:6] == 2'h0)
    else $error("address upper bits not zero");
  a_flag_clear: assert property (
    s_flag_clear |=> !s.refused)
    else $error("refusal flag not cleared by a one");
  a_flag_hold: assert property (
    s.refused && !stat_m[STAT_REFUSE] |=> s.refused)
    else $error("refusal flag lost without a clear");
  a_stall_cause: assert property (
    !cpu_stall && !start && !rd_go |=> !cpu_stall)
    else $error("stall without program or read");
  a_mode_write: assert property (
    !busy && !start && ctrl_m[CTRL_MODE+1 -: 2] == 2'h3 |=>
      mode == $past(wval[CTRL_MODE+1 -: 2]))
    else $error("mode write while idle lost");

endmodule

/* tb/eebac_nvm_model.sv */
// behavioural 64-byte nonvolatile array behind the access block
`timescale 1ns/1ns
module eebac_nvm_model (
  input  wire logic       clk,
  input  wire logic [5:0] arr_addr,
  input  wire logic [7:0] arr_wdata,
  input  wire logic       arr_erase,
  input  wire logic       arr_write,
  input  wire logic       arr_rd,
  output logic [7:0]      arr_rdata
);
  logic [7:0] mem [64];
  logic [7:0] last;
  // ****
  // array update, done at the strobe, not timed
  // ****
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'hFF;
    end
    last = 8'h00;
  end
  always @(posedge clk) begin
    if (arr_erase && arr_write) begin
      mem[arr_addr] <= arr_wdata;
    end else if (arr_erase) begin
      mem[arr_addr] <= 8'hFF;
    end else if (arr_write) begin
      // unerased bits stay low, so a stray write shows up
      mem[arr_addr] <= mem[arr_addr] & arr_wdata;
    end
    if (arr_rd) begin
      last <= mem[arr_addr];
    end
  end
  // outside a read the bus shows garbage, never the old value
  assign arr_rdata = arr_rd ? mem[arr_addr] : ~last;
endmodule

/* tb/eebac_top_bench.sv */
// self-checking bench for the eeprom byte access control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module eebac_top_bench;
  import eebac_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       por_rst = 1'b1;
  logic [6:0] io_addr = 7'h00;
  logic [2:0] io_bit_sel = 3'h0;
  logic [7:0] io_wdata = 8'h00;
  logic       io_ds = 1'b0;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic       io_sbi = 1'b0;
  logic       io_cbi = 1'b0;
  logic       gie = 1'b0;
  logic       osc_en = 1'b1;
  logic       osc_tick = 1'b0;
  logic       ds_sel = 1'b0;
  logic [2:0] tcnt = 3'h0;
  logic [7:0] io_rdata;
  logic       io_bit_val;
  logic       cpu_stall;
  logic       ready_irq;
  logic [5:0] arr_addr;
  logic [7:0] arr_wdata;
  logic       arr_erase;
  logic       arr_write;
  logic       arr_rd;
  logic [7:0] arr_rdata;
  logic [31:0] seed = 32'h20A3E3B0;
  logic [7:0] exp_mem [64];
  int         fails = 0;
  int         samples_checked = 0;

  always #5 clk = ~clk;
  // short tick period keeps the programming counts quick
  always @(negedge clk) begin
    tcnt <= tcnt + 3'h1;
    osc_tick <= osc_en && (tcnt == 3'h0);
  end

  eebac_top #(.ATOMIC_T(5), .SPLIT_T(3)) u_eebac_top (
    .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .io_addr(io_addr),
    .io_ds(io_ds), .io_wr(io_wr), .io_rd(io_rd), .io_sbi(io_sbi),
    .io_cbi(io_cbi), .io_bit_sel(io_bit_sel), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_bit_val(io_bit_val), .cpu_stall(cpu_stall),
    .gie(gie), .ready_irq(ready_irq), .osc_tick(osc_tick),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_erase(arr_erase),
    .arr_write(arr_write), .arr_rd(arr_rd), .arr_rdata(arr_rdata)
  );
  eebac_nvm_model u_eebac_nvm_model (
    .clk(clk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_erase(arr_erase), .arr_write(arr_write), .arr_rd(arr_rd),
    .arr_rdata(arr_rdata)
  );

  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] upd(input logic [1:0] m,
                                     input logic [7:0] o,
                                     input logic [7:0] d);
    case (m)
      2'h0: return d;
      2'h1: return 8'hFF;
      2'h2: return o & d;
      default: return o;
    endcase
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // k: 0 write, 1 set bit, 2 clear bit, 3 read; one cycle strobe
  task automatic bus(input int k, input logic [5:0] a,
                     input logic [7:0] d, input int b);
    @(negedge clk);
    io_addr = ds_sel ? {1'b0, a} + DS_OFFSET : {1'b0, a};
    io_ds = ds_sel;
    io_wdata = d;
    io_bit_sel = 3'(b);
    io_wr = (k == 0);
    io_sbi = (k == 1);
    io_cbi = (k == 2);
    io_rd = (k == 3);
    @(negedge clk);
    {io_wr, io_sbi, io_cbi, io_rd} = 4'h0;
  endtask
  task automatic rd(input logic [5:0] a, input int b,
                    output logic [7:0] v);
    bus(3, a, 8'h00, b);
    v = io_rdata;
  endtask
  task automatic stall_cnt(output int n);
    n = 0;
    repeat (8) begin
      if (cpu_stall === 1'b1) begin
        n++;
      end
      @(negedge clk);
    end
  endtask
  task automatic wait_idle;
    logic [7:0] v;
    for (int i = 0; i < 300; i++) begin
      rd(OFS_CTRL, CTRL_GO, v);
      if (v[CTRL_GO] === 1'b0) return;
    end
    fails++;
    $display("Error busy expected 0 seen 1");
    close_out;
  endtask
  // arm, then go after k+1 idle cycles; go lands k+2 edges after arm
  task automatic prog(input logic [1:0] m, input logic [5:0] a,
                      input logic [7:0] d, input int k);
    bus(0, OFS_CTRL, {2'b00, m, 4'h0}, 0);
    bus(0, OFS_ADDR, {2'b00, a}, 0);
    bus(0, OFS_DATA, d, 0);
    bus(1, OFS_CTRL, 8'h00, CTRL_ARM);
    repeat (k) @(negedge clk);
    bus(1, OFS_CTRL, 8'h00, CTRL_GO);
  endtask
  task automatic rd_back(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    int n;
    bus(0, OFS_ADDR, {2'b00, a}, 0);
    bus(1, OFS_CTRL, 8'h00, CTRL_READ);
    stall_cnt(n);
    `CHK("read stall", 4, n)
    rd(OFS_DATA, 0, v);
    `CHK("read data", e, v)
  endtask

  // ****
  // main sequence
  // ****
  logic [1:0] tm [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  int         tk [5] = '{0, 2, 1, 0, 3};
  logic       tn [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  initial begin
    logic [7:0] v;
    logic [5:0] a;
    logic [7:0] d;
    logic [31:0] r;
    logic st;
    int n;
    for (int i = 0; i < 64; i++) begin
      exp_mem[i] = 8'hFF;
    end
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    por_rst = 1'b0;
    rd(OFS_CTRL, 0, v);
    `CHK("ctrl reset", 8'h00, v)
    rd(OFS_ADDR, 0, v);
    `CHK("addr reset", ADDR_RST, v[5:0])
    rd(OFS_STAT, 0, v);
    `CHK("stat reset", 8'h00, v)
    bus(0, OFS_ADDR, 8'hFF, 0);
    rd(OFS_ADDR, 0, v);
    `CHK("addr width", 8'h3F, v)
    // arm window: seen at the 2nd edge after arming, gone at the 5th
    bus(1, OFS_CTRL, 8'h00, CTRL_ARM);
    rd(OFS_CTRL, 0, v);
    `CHK("arm early", 1'b1, v[CTRL_ARM])
    @(negedge clk);
    rd(OFS_CTRL, 0, v);
    `CHK("arm late", 1'b0, v[CTRL_ARM])
    bus(1, OFS_CTRL, 8'h00, CTRL_GO);
    rd(OFS_CTRL, 0, v);
    `CHK("go unarmed", 1'b0, v[CTRL_GO])
    // every mode, write-only after erase, last go outside the window
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      if (tn[i]) begin
        a = r[5:0];
      end
      d = r[15:8];
      st = tk[i] < 3;
      prog(tm[i], a, d, tk[i]);
      stall_cnt(n);
      `CHK("prog stall", st ? 2 : 0, n)
      rd(OFS_CTRL, 0, v);
      `CHK("busy", st && tm[i] != 2'h3, v[CTRL_GO])
      wait_idle;
      if (st) begin
        exp_mem[a] = upd(tm[i], exp_mem[a], d);
      end
      rd_back(a, exp_mem[a]);
    end
    // busy lockouts with the oscillator halted
    gie = 1'b1;
    r = rnd();
    a = r[5:0];
    d = r[15:8];
    prog(2'h0, a, d, 0);
    osc_en = 1'b0;
    bus(1, OFS_CTRL, 8'h00, CTRL_IRQEN);
    rd(OFS_CTRL, CTRL_GO, v);
    `CHK("ctrl busy", 8'h0A, v)
    `CHK("skip bit", 1'b1, io_bit_val)
    `CHK("irq busy", 1'b0, ready_irq)
    bus(0, OFS_ADDR, {2'b00, ~a}, 0);
    rd(OFS_ADDR, 0, v);
    `CHK("addr lock", {2'b00, a}, v)
    bus(1, OFS_STAT, 8'h00, STAT_REFUSE);
    bus(0, OFS_CTRL, 8'h18, 0);
    rd(OFS_CTRL, 0, v);
    `CHK("mode lock", 2'h0, v[5:4])
    bus(1, OFS_CTRL, 8'h00, CTRL_READ);
    rd(OFS_STAT, 0, v);
    `CHK("refused", 1'b1, v[STAT_REFUSE])
    bus(1, OFS_STAT, 8'h00, 1);
    rd(OFS_STAT, 0, v);
    `CHK("flag kept", 1'b1, v[STAT_REFUSE])
    bus(1, OFS_STAT, 8'h00, STAT_REFUSE);
    rd(OFS_STAT, 0, v);
    `CHK("flag clear", 1'b0, v[STAT_REFUSE])
    repeat (40) @(negedge clk);
    rd(OFS_CTRL, 0, v);
    `CHK("no ticks", 1'b1, v[CTRL_GO])
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    osc_en = 1'b1;
    wait_idle;
    exp_mem[a] = d;
    rd_back(a, d);
    bus(1, OFS_CTRL, 8'h00, CTRL_IRQEN);
    `CHK("irq ready", 1'b1, ready_irq)
    gie = 1'b0;
    @(negedge clk);
    `CHK("irq gated", 1'b0, ready_irq)
    bus(2, OFS_CTRL, 8'h00, CTRL_IRQEN);
    rd(OFS_CTRL, 0, v);
    `CHK("cbi ctrl", 8'h00, v)
    // data-space alias and an unmapped place
    ds_sel = 1'b1;
    bus(0, OFS_ADDR, 8'h2A, 0);
    ds_sel = 1'b0;
    rd(OFS_ADDR, 0, v);
    `CHK("ds alias", 8'h2A, v)
    bus(0, 6'h05, 8'hA5, 0);
    rd(6'h05, 0, v);
    `CHK("unmapped", 8'h00, v)
    close_out;
  end
endmodule
